// ### dv/ssic_core_model.sv
`timescale 1ns/10ps

module ssic_core_model (
  // Clock
  input  wire logic        clk_sys_i,
  // CSR request side
  output logic             csr_valid_o,
  output logic             csr_write_o,
  output logic [11:0]      csr_addr_o,
  output logic [31:0]      csr_wdata_o,
  output logic             priv_machine_o,
  input  wire logic        csr_ack_i,
  input  wire logic        csr_fault_i,
  input  wire logic [31:0] csr_rdata_i,
  // Instruction events
  output logic             wfe_o,
  output logic             wfi_o,
  output logic             ret_o,
  output logic             to_main_o
);
  // Idle core: no access, no instruction
  initial begin
    csr_valid_o = 1'b0;
    csr_write_o = 1'b0;
    csr_addr_o = 12'h000;
    csr_wdata_o = 32'h0000_0000;
    priv_machine_o = 1'b1;
    wfe_o = 1'b0;
    wfi_o = 1'b0;
    ret_o = 1'b0;
    to_main_o = 1'b0;
  end

  // One CSR instruction; the answer is registered, so it is read a cycle on
  task automatic csr(input logic wr, input logic [11:0] a,
                     input logic [31:0] w, input logic m,
                     output logic ack, output logic fault,
                     output logic [31:0] rd);
    csr_valid_o = 1'b1;
    csr_write_o = wr;
    csr_addr_o = a;
    csr_wdata_o = w;
    priv_machine_o = m;
    @(negedge clk_sys_i);
    ack = csr_ack_i;
    fault = csr_fault_i;
    rd = csr_rdata_i;
    // Released lines carry garbage, not the last value
    csr_valid_o = 1'b0;
    csr_addr_o = ~a;
    csr_wdata_o = ~w;
    @(negedge clk_sys_i);
  endtask

  // Wait or return instruction: 0 event wait, 1 interrupt wait, 2 return
  task automatic op(input int k, input logic main);
    wfe_o = (k == 0);
    wfi_o = (k == 1);
    ret_o = (k == 2);
    to_main_o = main;
    @(negedge clk_sys_i);
    wfe_o = 1'b0;
    wfi_o = 1'b0;
    ret_o = 1'b0;
    to_main_o = 1'b0;
  endtask
endmodule

// ### dv/testbench.sv
`timescale 1ns/10ps
`include "ssic_defines.svh"

module testbench;
  // Stimulus, outputs and reference state
  logic         clk_sys_i, rst_n_i, sctl_valid, sctl_write, deadlock, ev_in;
  logic [31:0]  sctl_wdata, rd, c_wdata, c_rdata, sctl_rdata, m_isc, m_sctl;
  logic [255:0] pend, en, rv;
  logic [11:0]  c_addr;
  logic [7:0]   act, req;
  logic         c_valid, c_write, c_mach, wfe, wfi, ret, to_main, c_ack;
  logic         c_fault, ack, fault, rst_req, sleep, deep, wake;
  logic         gie, stk, nest, pre;
  int           miscompares, n_checks, cyc;
  localparam logic [11:0] ISC = `SSIC_ISC_CSR_ADDR;

  ssic_sleep_int_ctrl i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .ce_i(1'b1), .csr_valid_i(c_valid), .csr_write_i(c_write),
    .csr_addr_i(c_addr), .csr_wdata_i(c_wdata), .priv_machine_i(c_mach),
    .csr_ack_o(c_ack), .csr_fault_o(c_fault), .csr_rdata_o(c_rdata),
    .sctl_valid_i(sctl_valid), .sctl_write_i(sctl_write),
    .sctl_wdata_i(sctl_wdata), .sctl_rdata_o(sctl_rdata), .wfe_exec_i(wfe),
    .wfi_exec_i(wfi), .isr_return_i(ret), .return_to_main_i(to_main),
    .core_deadlock_i(deadlock), .event_in_i(ev_in), .int_pending_i(pend),
    .int_enable_i(en), .act_prio_i(act), .req_prio_i(req),
    .sys_reset_req_o(rst_req), .sleep_o(sleep), .deep_sleep_o(deep),
    .wake_o(wake), .global_int_en_o(gie), .auto_stack_en_o(stk),
    .nesting_en_o(nest), .preempt_o(pre));

  ssic_core_model i_core (.clk_sys_i(clk_sys_i), .csr_valid_o(c_valid),
    .csr_write_o(c_write), .csr_addr_o(c_addr), .csr_wdata_o(c_wdata),
    .priv_machine_o(c_mach), .csr_ack_i(c_ack), .csr_fault_i(c_fault),
    .csr_rdata_i(c_rdata), .wfe_o(wfe), .wfi_o(wfi), .ret_o(ret),
    .to_main_o(to_main));

  // Clock
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task automatic tick();
    @(negedge clk_sys_i);
  endtask

  // Compare tasks, one per result width
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Cuts a hang short; the tests need under a hundred cycles
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      final_report();
    end
  end

  // Interrupt control outputs follow the reference copy
  task automatic isc_outs();
    chk_bit("global_int_en", !m_isc[5], gie);
    chk_bit("auto_stack_en", m_isc[0] & !m_isc[5], stk);
    chk_bit("nesting_en", m_isc[1], nest);
  endtask

  task automatic csr(input logic wr, input logic [11:0] a,
                     input logic [31:0] w, input logic m);
    i_core.csr(wr, a, w, m, ack, fault, rd);
    if (a == ISC && m && wr) m_isc = {26'h0, m_isc[5] | w[5], 3'h0, w[1:0]};
    chk_bit("csr_ack", a == ISC, ack);
    if (a == ISC) begin
      chk_bit("csr_fault", !m, fault);
      chk_word("csr_rdata", m ? m_isc : 32'h0, rd);
    end
    isc_outs();
  endtask

  // Back-to-back calls are avoided: the strobe is dropped, not re-raised
  task automatic sctl_wr(input logic [31:0] w);
    sctl_valid = 1'b1;
    sctl_write = 1'b1;
    sctl_wdata = w;
    tick();
    sctl_valid = 1'b0;
    sctl_wdata = ~w;
    m_sctl = w & 32'h0000_005e;
    chk_word("sctl", m_sctl, sctl_rdata);
    chk_bit("reset_req", w[31], rst_req);
  endtask

  task automatic slp(input logic s, input logic wk);
    chk_bit("sleep", s, sleep);
    chk_bit("deep_sleep", s & m_sctl[2], deep);
    chk_bit("wake", wk, wake);
  endtask

  // One wait, one stimulus while asleep, then an enabled line if still asleep
  task automatic sleep_case(input logic [31:0] cfg, input int k,
                            input logic [255:0] p, input logic [255:0] e,
                            input logic v, input logic x);
    sctl_wr(cfg);
    i_core.op(k, 1'b0);
    slp(1'b1, 1'b0);
    pend = p;
    en = e;
    ev_in = v;
    tick();
    slp(!x, x);
    pend = x ? 256'h0 : 256'h1;
    en = x ? 256'h0 : 256'h1;
    ev_in = 1'b0;
    if (!x) begin
      tick();
      pend = 256'h0;
      en = 256'h0;
      slp(1'b0, 1'b1);
    end
  endtask

  // Main sequence
  initial begin
    {rst_n_i, sctl_valid, sctl_write, deadlock, ev_in} = 5'h00;
    {sctl_wdata, m_isc, m_sctl} = 96'h0;
    {pend, en, act, req} = 528'h0;
    void'($urandom(32'h6fa6));
    repeat (6) tick();
    rst_n_i = 1'b1;
    chk_word("sctl", 32'h0, sctl_rdata);
    csr(1'b0, ISC, 32'h0, 1'b1);
    csr(1'b1, ISC, 32'hffff_ffff, 1'b1);
    i_core.op(2, 1'b0);
    m_isc[5] = 1'b0;
    isc_outs();
    csr(1'b1, ISC, 32'h0000_0020, 1'b0);
    csr(1'b0, 12'h805, 32'h0, 1'b1);
    repeat (6) csr(1'b1, ISC, $urandom(), $urandom() % 4 != 0);
    i_core.op(2, 1'b0);
    m_isc[5] = 1'b0;
    isc_outs();
    $display("test csr done");
    sctl_wr(32'h8000_0000);
    deadlock = 1'b1;
    tick();
    deadlock = 1'b0;
    chk_bit("reset_req", 1'b1, rst_req);
    sctl_wr(32'hffff_ff40);
    deadlock = 1'b1;
    tick();
    deadlock = 1'b0;
    chk_bit("reset_req", 1'b0, rst_req);
    $display("test system control done");
    rv = {8{$urandom()}} | 256'h1;
    sleep_case(32'h04, 0, 256'h0, 256'h0, 1'b1, 1'b1);
    sleep_case(32'h10, 0, rv, ~rv, 1'b0, 1'b1);
    sleep_case(32'h00, 0, rv, ~rv, 1'b0, 1'b0);
    sleep_case(32'h08, 1, 256'h0, 256'h0, 1'b1, 1'b1);
    sleep_case(32'h18, 1, rv, ~rv, 1'b0, 1'b1);
    sleep_case(32'h04, 1, rv, rv, 1'b0, 1'b1);
    // The interrupt wake above fell outside an event wait and was kept
    i_core.op(0, 1'b0);
    slp(1'b0, 1'b1);
    tick();
    i_core.op(0, 1'b0);
    slp(1'b1, 1'b0);
    sctl_wr(32'h24);
    slp(1'b0, 1'b1);
    ev_in = 1'b1;
    tick();
    ev_in = 1'b0;
    i_core.op(0, 1'b0);
    slp(1'b0, 1'b1);
    sctl_wr(32'h02);
    i_core.op(2, 1'b1);
    slp(1'b1, 1'b0);
    pend = 256'h1;
    en = 256'h1;
    tick();
    {pend, en} = 512'h0;
    slp(1'b0, 1'b1);
    sctl_wr(32'h00);
    i_core.op(2, 1'b1);
    slp(1'b0, 1'b0);
    sleep_case(32'h10, 1, rv, ~rv, 1'b0, 1'b0);
    $display("test sleep done");
    csr(1'b1, ISC, 32'h2, 1'b1);
    repeat (8) begin
      act = 8'($urandom());
      req = 8'($urandom());
      tick();
      chk_bit("preempt", req[7] < act[7], pre);
    end
    csr(1'b1, ISC, 32'h0, 1'b1);
    act = 8'h80;
    req = 8'h00;
    tick();
    chk_bit("preempt", 1'b0, pre);
    $display("test preempt done");
    final_report();
  end
endmodule

// ### src/ssic_core_if.sv
`timescale 1ns/10ps
`include "ssic_defines.svh"

interface ssic_core_if;
  // Wake detection
  logic [`SSIC_INT_NUM-1:0] int_pending;
  logic [`SSIC_INT_NUM-1:0] int_enable;
  logic                     pend_wakes;
  logic                     int_wake_en;
  logic                     int_wake_any;
  // Preemption check
  logic [`SSIC_PRIO_W-1:0]  act_prio;
  logic [`SSIC_PRIO_W-1:0]  req_prio;
  logic                     nest_en;
  logic                     preempt;

  modport top_mp (
    output int_pending, int_enable, pend_wakes, act_prio, req_prio, nest_en,
    input  int_wake_en, int_wake_any, preempt
  );
  modport wake_mp (
    input  int_pending, int_enable, pend_wakes,
    output int_wake_en, int_wake_any
  );
  modport prio_mp (
    input  act_prio, req_prio, nest_en,
    output preempt
  );
endinterface

// ### src/ssic_defines.svh
`ifndef SSIC_DEFINES_SVH
`define SSIC_DEFINES_SVH

// Register access
`define SSIC_ISC_CSR_ADDR     12'h804
`define SSIC_ISC_RESET        32'h0000_0000
`define SSIC_SCTL_RESET       32'h0000_0000

// Interrupt system control fields
`define SSIC_ISC_KILL_BIT     5
`define SSIC_ISC_NEST_BIT     1
`define SSIC_ISC_STACK_BIT    0

// System control fields
`define SSIC_SCTL_RESET_BIT   31
`define SSIC_SCTL_DLOCK_BIT   6
`define SSIC_SCTL_EVENT_BIT   5
`define SSIC_SCTL_PEND_BIT    4
`define SSIC_SCTL_WFI_BIT     3
`define SSIC_SCTL_DEEP_BIT    2
`define SSIC_SCTL_EXIT_BIT    1

// Sizes
`define SSIC_INT_NUM          256
`define SSIC_PRIO_W           8
`define SSIC_PREEMPT_BIT      7

`endif

// ### src/ssic_pkg.sv
package ssic_pkg;

  // Low-power sequencer states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_WAIT_INT,
    ST_WAIT_EVT
  } ssic_state_t;

  typedef logic [31:0] ssic_word_t;

endpackage

// ### src/ssic_preempt_check.sv
`timescale 1ns/10ps
`include "ssic_defines.svh"

module ssic_preempt_check
  import ssic_pkg::*;
(
  // Active and requesting priorities in, preempt decision out
  ssic_core_if.prio_mp cif
);

  // With nesting enabled, only the top bit decides preemption; smaller value is more urgent
  assign cif.preempt = cif.nest_en &
                       (cif.req_prio[`SSIC_PREEMPT_BIT] <
                        cif.act_prio[`SSIC_PREEMPT_BIT]);

endmodule

// ### src/ssic_sleep_int_ctrl.sv
`timescale 1ns/10ps
`include "ssic_defines.svh"

module ssic_sleep_int_ctrl
  import ssic_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     ce_i,
  // CSR port from the core
  input  wire logic                     csr_valid_i,
  input  wire logic                     csr_write_i,
  input  wire logic [11:0]              csr_addr_i,
  input  wire logic [31:0]              csr_wdata_i,
  input  wire logic                     priv_machine_i,
  output logic                          csr_ack_o,
  output logic                          csr_fault_o,
  output logic [31:0]                   csr_rdata_o,
  // System control register port
  input  wire logic                     sctl_valid_i,
  input  wire logic                     sctl_write_i,
  input  wire logic [31:0]              sctl_wdata_i,
  output logic [31:0]                   sctl_rdata_o,
  // Core events
  input  wire logic                     wfe_exec_i,
  input  wire logic                     wfi_exec_i,
  input  wire logic                     isr_return_i,
  input  wire logic                     return_to_main_i,
  input  wire logic                     core_deadlock_i,
  input  wire logic                     event_in_i,
  // Interrupt lines and priorities
  input  wire logic [`SSIC_INT_NUM-1:0] int_pending_i,
  input  wire logic [`SSIC_INT_NUM-1:0] int_enable_i,
  input  wire logic [`SSIC_PRIO_W-1:0]  act_prio_i,
  input  wire logic [`SSIC_PRIO_W-1:0]  req_prio_i,
  // Control outputs
  output logic                          sys_reset_req_o,
  output logic                          sleep_o,
  output logic                          deep_sleep_o,
  output logic                          wake_o,
  output logic                          global_int_en_o,
  output logic                          auto_stack_en_o,
  output logic                          nesting_en_o,
  output logic                          preempt_o
);

  ssic_core_if cif ();

  // Register state
  logic        deadlock_reset_disable_ff, nxt_deadlock_reset_disable;
  logic        pending_wakes_event_ff,    nxt_pending_wakes_event;
  logic        wait_int_as_wait_event_ff, nxt_wait_int_as_wait_event;
  logic        deep_low_power_select_ff,  nxt_deep_low_power_select;
  logic        low_power_on_isr_return_ff, nxt_low_power_on_isr_return;
  logic        global_int_stack_kill_ff,  nxt_global_int_stack_kill;
  logic        nesting_enable_ff,         nxt_nesting_enable;
  logic        auto_stacking_enable_ff,   nxt_auto_stacking_enable;
  logic        csr_ack_ff,   nxt_csr_ack;
  logic        csr_fault_ff, nxt_csr_fault;
  logic [31:0] csr_rdata_ff, nxt_csr_rdata;
  logic [31:0] sctl_rdata_ff, nxt_sctl_rdata;
  logic        sys_reset_ff, nxt_sys_reset;
  // Sequencer state
  ssic_state_t state_ff, nxt_state;
  logic        evt_latch_ff, nxt_evt_latch;
  logic        wake_ff, nxt_wake;
  logic        sleep_ff, nxt_sleep;
  logic        deep_ff, nxt_deep;
  logic        preempt_ff, nxt_preempt;
  logic        gie_ff, nxt_gie;
  logic        stk_ff, nxt_stk;

  logic        csr_hit;
  logic        csr_ok;
  logic        csr_wr;
  logic        sctl_wr;
  logic        raise_evt;
  logic        evt_cond;
  logic        wfe_now;

  // Feed the helper modules
  assign cif.int_pending = int_pending_i;
  assign cif.int_enable  = int_enable_i;
  assign cif.pend_wakes  = pending_wakes_event_ff;
  assign cif.act_prio    = act_prio_i;
  assign cif.req_prio    = req_prio_i;
  assign cif.nest_en     = nesting_enable_ff;

  ssic_wake_detect u_wake (
    .cif (cif.wake_mp)
  );

  ssic_preempt_check u_prio (
    .cif (cif.prio_mp)
  );

  // Access decode; a user-mode access is refused without side effect
  assign csr_hit   = csr_valid_i && (csr_addr_i == `SSIC_ISC_CSR_ADDR);
  assign csr_ok    = csr_hit && priv_machine_i;
  assign csr_wr    = csr_ok && csr_write_i;
  assign sctl_wr   = sctl_valid_i && sctl_write_i;
  assign raise_evt = sctl_wr && sctl_wdata_i[`SSIC_SCTL_EVENT_BIT];
  // Any wake source, interrupt part shaped by the pending-wakes bit
  assign evt_cond  = event_in_i || raise_evt || cif.int_wake_any;
  // A wait-for-interrupt may be converted into a wait-for-event
  assign wfe_now   = wfe_exec_i ||
                     (wfi_exec_i && wait_int_as_wait_event_ff);

  // Register next values; only defined bits are stored
  always_comb begin
    nxt_deadlock_reset_disable  = deadlock_reset_disable_ff;
    nxt_pending_wakes_event     = pending_wakes_event_ff;
    nxt_wait_int_as_wait_event  = wait_int_as_wait_event_ff;
    nxt_deep_low_power_select   = deep_low_power_select_ff;
    nxt_low_power_on_isr_return = low_power_on_isr_return_ff;
    nxt_nesting_enable          = nesting_enable_ff;
    nxt_auto_stacking_enable    = auto_stacking_enable_ff;
    nxt_global_int_stack_kill   = global_int_stack_kill_ff;
    if (sctl_wr) begin
      nxt_deadlock_reset_disable  = sctl_wdata_i[`SSIC_SCTL_DLOCK_BIT];
      nxt_pending_wakes_event     = sctl_wdata_i[`SSIC_SCTL_PEND_BIT];
      nxt_wait_int_as_wait_event  = sctl_wdata_i[`SSIC_SCTL_WFI_BIT];
      nxt_deep_low_power_select   = sctl_wdata_i[`SSIC_SCTL_DEEP_BIT];
      nxt_low_power_on_isr_return = sctl_wdata_i[`SSIC_SCTL_EXIT_BIT];
    end
    if (csr_wr) begin
      nxt_nesting_enable       = csr_wdata_i[`SSIC_ISC_NEST_BIT];
      nxt_auto_stacking_enable = csr_wdata_i[`SSIC_ISC_STACK_BIT];
    end
    // Return clears the kill bit, but a same-cycle set wins
    if (isr_return_i) begin
      nxt_global_int_stack_kill = 1'b0;
    end
    if (csr_wr && csr_wdata_i[`SSIC_ISC_KILL_BIT]) begin
      nxt_global_int_stack_kill = 1'b1;
    end
    // Registered copies so these outputs come straight from flops
    nxt_gie = ~nxt_global_int_stack_kill;
    nxt_stk = nxt_auto_stacking_enable & ~nxt_global_int_stack_kill;
  end

  // Access answers and reset request; reserved and write-only bits read 0
  always_comb begin
    nxt_csr_ack   = csr_hit;
    nxt_csr_fault = csr_hit && !priv_machine_i;
    nxt_csr_rdata = 32'h0000_0000;
    if (csr_ok) begin
      nxt_csr_rdata[`SSIC_ISC_KILL_BIT]  = nxt_global_int_stack_kill;
      nxt_csr_rdata[`SSIC_ISC_NEST_BIT]  = nxt_nesting_enable;
      nxt_csr_rdata[`SSIC_ISC_STACK_BIT] = nxt_auto_stacking_enable;
    end
    nxt_sctl_rdata = 32'h0000_0000;
    nxt_sctl_rdata[`SSIC_SCTL_DLOCK_BIT] = nxt_deadlock_reset_disable;
    nxt_sctl_rdata[`SSIC_SCTL_PEND_BIT]  = nxt_pending_wakes_event;
    nxt_sctl_rdata[`SSIC_SCTL_WFI_BIT]   = nxt_wait_int_as_wait_event;
    nxt_sctl_rdata[`SSIC_SCTL_DEEP_BIT]  = nxt_deep_low_power_select;
    nxt_sctl_rdata[`SSIC_SCTL_EXIT_BIT]  = nxt_low_power_on_isr_return;
    // Reset bit is never stored, so it reads zero after the pulse
    nxt_sys_reset = (sctl_wr && sctl_wdata_i[`SSIC_SCTL_RESET_BIT])
                 || (core_deadlock_i && !deadlock_reset_disable_ff);
  end

  // Low-power sequencer next values
  always_comb begin
    nxt_state     = state_ff;
    nxt_evt_latch = evt_latch_ff;
    nxt_wake      = 1'b0;
    nxt_preempt   = cif.preempt;
    // A wake outside an event wait is kept for the next event wait
    if (evt_cond && (state_ff != ST_WAIT_EVT) && !wfe_now) begin
      nxt_evt_latch = 1'b1;
    end
    case (state_ff)
      ST_RUN: begin
        if (wfe_now) begin
          if (evt_latch_ff || evt_cond) begin
            nxt_wake      = 1'b1;
            nxt_evt_latch = 1'b0;
          end else begin
            nxt_state = ST_WAIT_EVT;
          end
        end else if (wfi_exec_i) begin
          if (cif.int_wake_en) begin
            nxt_wake = 1'b1;
          end else begin
            nxt_state = ST_WAIT_INT;
          end
        end else if (isr_return_i && return_to_main_i &&
                     low_power_on_isr_return_ff) begin
          nxt_state = ST_WAIT_INT;
        end
      end
      ST_WAIT_INT: begin
        if (cif.int_wake_en) begin
          nxt_state = ST_RUN;
          nxt_wake  = 1'b1;
        end
      end
      ST_WAIT_EVT: begin
        if (evt_cond) begin
          nxt_state = ST_RUN;
          nxt_wake  = 1'b1;
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
    nxt_sleep = (nxt_state != ST_RUN);
    // Depth is sampled continuously so a late change still takes effect
    nxt_deep  = nxt_sleep && deep_low_power_select_ff;
  end

  // All state frozen while the clock enable is low
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      deadlock_reset_disable_ff  <= 1'b0;
      pending_wakes_event_ff     <= 1'b0;
      wait_int_as_wait_event_ff  <= 1'b0;
      deep_low_power_select_ff   <= 1'b0;
      low_power_on_isr_return_ff <= 1'b0;
      global_int_stack_kill_ff   <= 1'b0;
      nesting_enable_ff          <= 1'b0;
      auto_stacking_enable_ff    <= 1'b0;
      csr_ack_ff                 <= 1'b0;
      csr_fault_ff               <= 1'b0;
      csr_rdata_ff               <= `SSIC_ISC_RESET;
      sctl_rdata_ff              <= `SSIC_SCTL_RESET;
      sys_reset_ff               <= 1'b0;
      state_ff                   <= ST_RUN;
      evt_latch_ff               <= 1'b0;
      wake_ff                    <= 1'b0;
      sleep_ff                   <= 1'b0;
      deep_ff                    <= 1'b0;
      preempt_ff                 <= 1'b0;
      gie_ff                     <= 1'b1;
      stk_ff                     <= 1'b0;
    end else if (ce_i) begin
      deadlock_reset_disable_ff  <= nxt_deadlock_reset_disable;
      pending_wakes_event_ff     <= nxt_pending_wakes_event;
      wait_int_as_wait_event_ff  <= nxt_wait_int_as_wait_event;
      deep_low_power_select_ff   <= nxt_deep_low_power_select;
      low_power_on_isr_return_ff <= nxt_low_power_on_isr_return;
      global_int_stack_kill_ff   <= nxt_global_int_stack_kill;
      nesting_enable_ff          <= nxt_nesting_enable;
      auto_stacking_enable_ff    <= nxt_auto_stacking_enable;
      csr_ack_ff                 <= nxt_csr_ack;
      csr_fault_ff               <= nxt_csr_fault;
      csr_rdata_ff               <= nxt_csr_rdata;
      sctl_rdata_ff              <= nxt_sctl_rdata;
      sys_reset_ff               <= nxt_sys_reset;
      state_ff                   <= nxt_state;
      evt_latch_ff               <= nxt_evt_latch;
      wake_ff                    <= nxt_wake;
      sleep_ff                   <= nxt_sleep;
      deep_ff                    <= nxt_deep;
      preempt_ff                 <= nxt_preempt;
      gie_ff                     <= nxt_gie;
      stk_ff                     <= nxt_stk;
    end
  end

  // Outputs straight from flops
  assign csr_ack_o       = csr_ack_ff;
  assign csr_fault_o     = csr_fault_ff;
  assign csr_rdata_o     = csr_rdata_ff;
  assign sctl_rdata_o    = sctl_rdata_ff;
  assign sys_reset_req_o = sys_reset_ff;
  assign sleep_o         = sleep_ff;
  assign deep_sleep_o    = deep_ff;
  assign wake_o          = wake_ff;
  assign global_int_en_o = gie_ff;
  assign auto_stack_en_o = stk_ff;
  assign nesting_en_o    = nesting_enable_ff;
  assign preempt_o       = preempt_ff;

  // Checks
  property p_soft_reset;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && sctl_wr && sctl_wdata_i[31] |=> sys_reset_req_o
      && !sctl_rdata_o[31];
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset write gave no reset pulse");

  property p_deadlock;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && core_deadlock_i
      && !(sctl_wr && sctl_wdata_i[31]) |=>
      (sys_reset_req_o == !$past(deadlock_reset_disable_ff));
  endproperty
  a_deadlock: assert property (p_deadlock)
    else $error("deadlock reset polarity wrong");

  property p_evt_wait_wake;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && state_ff == ST_WAIT_EVT && raise_evt |=> wake_o && !sleep_o;
  endproperty
  a_evt_wait_wake: assert property (p_evt_wait_wake)
    else $error("raised event did not wake event wait");

  property p_latched_wfe;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && state_ff == ST_RUN && evt_latch_ff && wfe_exec_i
      |=> wake_o && !sleep_o && !evt_latch_ff;
  endproperty
  a_latched_wfe: assert property (p_latched_wfe)
    else $error("remembered wake did not end wait at once");

  property p_wfi_as_wfe;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && state_ff == ST_RUN && wfi_exec_i && wait_int_as_wait_event_ff
      && !evt_latch_ff && !evt_cond |=> state_ff == ST_WAIT_EVT;
  endproperty
  a_wfi_as_wfe: assert property (p_wfi_as_wfe)
    else $error("converted wait did not wait for event");

  property p_deep;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ##1 (deep_sleep_o == (sleep_o && $past(deep_low_power_select_ff)));
  endproperty
  a_deep: assert property (p_deep)
    else $error("deep sleep select mismatch");

  property p_exit_sleep;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && state_ff == ST_RUN && !wfe_now && !wfi_exec_i && isr_return_i
      && return_to_main_i && low_power_on_isr_return_ff |=> sleep_o;
  endproperty
  a_exit_sleep: assert property (p_exit_sleep)
    else $error("no low power after ISR return");

  property p_user_refused;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && csr_hit && !priv_machine_i |=> csr_fault_o
      && $stable(nesting_en_o) && csr_rdata_o == 32'h0000_0000;
  endproperty
  a_user_refused: assert property (p_user_refused)
    else $error("user-mode CSR access was not refused");

  property p_kill;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && csr_wr && csr_wdata_i[5] |=> !global_int_en_o && !auto_stack_en_o;
  endproperty
  a_kill: assert property (p_kill)
    else $error("kill bit did not stop interrupts and stacking");

  property p_kill_clear;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && isr_return_i && !(csr_wr && csr_wdata_i[5]) |=> global_int_en_o;
  endproperty
  a_kill_clear: assert property (p_kill_clear)
    else $error("kill bit not cleared on return");

  property p_preempt;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i |=> preempt_o == ($past(nesting_enable_ff)
      && !$past(req_prio_i[7]) && $past(act_prio_i[7]));
  endproperty
  a_preempt: assert property (p_preempt)
    else $error("preemption decision wrong");

endmodule

// ### src/ssic_wake_detect.sv
`timescale 1ns/10ps
`include "ssic_defines.svh"

module ssic_wake_detect
  import ssic_pkg::*;
(
  // Pending and enable vectors in, wake flags out
  ssic_core_if.wake_mp cif
);

  logic [`SSIC_INT_NUM-1:0] hit_en;
  logic [`SSIC_INT_NUM-1:0] hit_any;

  // Per-line wake terms; disabled lines count only when pending wakes
  genvar gi;
  generate
    for (gi = 0; gi < `SSIC_INT_NUM; gi = gi + 1) begin : g_line
      assign hit_en[gi]  = cif.int_pending[gi] & cif.int_enable[gi];
      assign hit_any[gi] = cif.int_pending[gi] &
                           (cif.int_enable[gi] | cif.pend_wakes);
    end
  endgenerate

  // Reduce to one flag each
  assign cif.int_wake_en  = |hit_en;
  assign cif.int_wake_any = |hit_any;

endmodule
